/* File: src/hsdma_pkg.sv */
package hsdma_pkg;

  // Host I/O addresses of the transfer registers (byte lanes)
  localparam logic [3:0] XFER_LO  = 4'h0;
  localparam logic [3:0] XFER_MID = 4'h1;
  localparam logic [3:0] XFER_HI  = 4'h2;
  // Host I/O addresses for slave control, status and interrupt count
  localparam logic [3:0] SEL_SLAVE = 4'h4;
  localparam logic [3:0] LOCKOUT   = 4'h5;
  localparam logic [3:0] SLV_RESET = 4'h6;
  localparam logic [3:0] STATUS    = 4'h7;
  localparam logic [3:0] IRQ_LO    = 4'h8;
  localparam logic [3:0] IRQ_HI    = 4'h9;

  // Slave internal bus addresses of the transfer register
  localparam logic [4:0] SLV_BUS_RD_ADDR = 5'h1F;
  localparam logic [4:0] SLV_BUS_WR_ADDR = 5'h1E;

  // Acknowledge timeout for a slave access, and expected interrupt count
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned ACK_TIMEOUT_US = 10;
  localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned IRQ_EXPECTED  = 1000;

  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [1:0]  RESET_SEL   = 2'h0;

  typedef enum {SA_IDLE, SA_REQ, SA_WRITE, SA_READ, SA_RELEASE} hsdma_state_e;

  // Host-side I/O request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } hsdma_io_s;

  // Slave memory access request
  typedef struct packed {
    logic        start;
    logic [15:0] addr;
    logic [7:0]  data;
  } hsdma_mem_s;

endpackage

/* File: src/hsdma_xfer_regs.sv */
`timescale 1ns/1ps
// Three byte-wide transfer registers for one direction
module hsdma_xfer_regs (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wrEn,
  input  wire logic [1:0]  wrSel,
  input  wire logic [7:0]  wrData,
  input  wire logic [1:0]  rdSel,
  output logic      [7:0]  rdData_q,
  output logic      [23:0] word_q
);

  ////////////////////////////////////////////////////////////////////////
  // Byte writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word_q <= 24'h000000;
    end else if (wrEn && wrSel != 2'h3) begin  // No fourth lane to write
      word_q[wrSel*8 +: 8] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= (rdSel == 2'h3) ? 8'h00 : word_q[rdSel*8 +: 8];
    end
  end

endmodule

/* File: src/hsdma_host.sv */
`timescale 1ns/1ps
// Operation
// - Decode slave select, drive one request low
// - Never two bus requests at once
// - No acknowledge after access means bus error
// - Acknowledged but wrong readback means data error
// - Assert lockout before slave memory accesses
// - Release reset, take bus, load, pulse reset
// - Count interrupts, fail on miscount when checked
// - Three byte registers per direction, I/O decoded
module hsdma_host (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire hsdma_pkg::hsdma_io_s  io,
  output logic      [7:0]        ioRdData,
  input  wire hsdma_pkg::hsdma_mem_s memReq,
  output logic                   memBusy,
  output logic                   memDone_q,
  output logic                   busError_q,
  output logic                   dataError_q,
  output logic      [7:0]        memRdData_q,
  output logic                   slave0_bus_request_n,
  output logic                   slave1_bus_request_n,
  input  wire logic              slave_bus_granted_n,
  input  wire logic              slave_transfer_ack_n,
  output logic      [15:0]       slvAddr_q,
  output logic      [7:0]        slvWrData_q,
  output logic                   slvWrite_q,
  output logic                   slvRead_q,
  input  wire logic [7:0]        slvRdData,
  output logic                   lockout_n,
  output logic                   slaveReset_n,
  input  wire logic              slave0_irq_n,
  input  wire logic              slave1_irq_n,
  input  wire logic              irqCheck,
  output logic                   irqCountOk,
  output logic      [23:0]       toSlaveWord,
  input  wire logic              slaveXferWr,
  input  wire logic [1:0]        slaveXferSel,
  input  wire logic [7:0]        slaveXferData
);

  ////////////////////////////////////////////////////////////////////////
  // I/O decode
  wire selWr    = io.wr && (io.addr == hsdma_pkg::SEL_SLAVE);
  wire lockWr   = io.wr && (io.addr == hsdma_pkg::LOCKOUT);
  wire rstWr    = io.wr && (io.addr == hsdma_pkg::SLV_RESET);
  wire xferHit  = (io.addr <= hsdma_pkg::XFER_HI);
  wire xferWr   = io.wr && xferHit;

  logic       sel_q;
  logic       selValid_q;
  logic       lock_q;
  logic       rst_q;
  logic [15:0] irqCnt_q;
  logic [1:0] irqSync_q;
  logic [7:0] fromSlaveByte;
  logic [23:0] fromSlaveWord;
  hsdma_pkg::hsdma_state_e state_q;
  logic [31:0] tmo_q;

  // Host-to-slave and slave-to-host byte banks
  hsdma_xfer_regs u_toSlave (
    .clock    (clock),
    .rstn     (rstn),
    .wrEn     (xferWr),
    .wrSel    (io.addr[1:0]),
    .wrData   (io.data),
    .rdSel    (2'h3),
    .rdData_q (),
    .word_q   (toSlaveWord)
  );
  hsdma_xfer_regs u_fromSlave (
    .clock    (clock),
    .rstn     (rstn),
    .wrEn     (slaveXferWr),
    .wrSel    (slaveXferSel),
    .wrData   (slaveXferData),
    .rdSel    (io.addr[1:0]),
    .rdData_q (fromSlaveByte),
    .word_q   (fromSlaveWord)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control bits: slave select, lockout, slave reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_q      <= 1'b0;
      selValid_q <= 1'b0;
      lock_q     <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      if (selWr && state_q == hsdma_pkg::SA_IDLE) begin
        sel_q      <= io.data[0];
        selValid_q <= 1'b1;
      end
      if (lockWr) lock_q <= io.data[0];
      if (rstWr) rst_q <= io.data[0];
    end
  end

  assign lockout_n    = ~lock_q;
  assign slaveReset_n = rst_q;

  // One request line only, never both
  wire reqActive = (state_q != hsdma_pkg::SA_IDLE) && (state_q != hsdma_pkg::SA_RELEASE);
  assign slave0_bus_request_n = ~(reqActive && !sel_q);
  assign slave1_bus_request_n = ~(reqActive &&  sel_q);
  assign memBusy = (state_q != hsdma_pkg::SA_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Slave memory access sequencer: write, then read back and compare
  wire tmoHit = (tmo_q == 32'(hsdma_pkg::ACK_TIMEOUT_CYC));
  wire ackLow = !slave_transfer_ack_n;
  wire canStart = memReq.start && selValid_q && lock_q && slave_bus_granted_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q     <= hsdma_pkg::SA_IDLE;
      tmo_q       <= 32'h00000000;
      slvAddr_q   <= 16'h0000;
      slvWrData_q <= 8'h00;
      slvWrite_q  <= 1'b0;
      slvRead_q   <= 1'b0;
      memDone_q   <= 1'b0;
      busError_q  <= 1'b0;
      dataError_q <= 1'b0;
      memRdData_q <= 8'h00;
    end else begin
      memDone_q <= 1'b0;
      case (state_q)
        hsdma_pkg::SA_IDLE: begin
          tmo_q <= 32'h00000000;
          if (canStart) begin
            slvAddr_q   <= memReq.addr;
            slvWrData_q <= memReq.data;
            busError_q  <= 1'b0;
            dataError_q <= 1'b0;
            state_q     <= hsdma_pkg::SA_REQ;
          end
        end
        hsdma_pkg::SA_REQ: begin
          tmo_q <= tmo_q + 32'h1;
          if (!slave_bus_granted_n) begin
            slvWrite_q <= 1'b1;
            tmo_q      <= 32'h00000000;
            state_q    <= hsdma_pkg::SA_WRITE;
          end else if (tmoHit) begin
            busError_q <= 1'b1;
            state_q    <= hsdma_pkg::SA_RELEASE;
          end
        end
        hsdma_pkg::SA_WRITE: begin
          tmo_q <= tmo_q + 32'h1;
          if (ackLow) begin
            slvWrite_q <= 1'b0;
            slvRead_q  <= 1'b1;
            tmo_q      <= 32'h00000000;
            state_q    <= hsdma_pkg::SA_READ;
          end else if (tmoHit) begin
            slvWrite_q <= 1'b0;
            busError_q <= 1'b1;
            state_q    <= hsdma_pkg::SA_RELEASE;
          end
        end
        hsdma_pkg::SA_READ: begin
          tmo_q <= tmo_q + 32'h1;
          if (ackLow && !slvWrite_q && tmo_q != 32'h0) begin
            slvRead_q   <= 1'b0;
            memRdData_q <= slvRdData;
            dataError_q <= (slvRdData != slvWrData_q);
            state_q     <= hsdma_pkg::SA_RELEASE;
          end else if (tmoHit) begin
            slvRead_q  <= 1'b0;
            busError_q <= 1'b1;
            state_q    <= hsdma_pkg::SA_RELEASE;
          end
        end
        hsdma_pkg::SA_RELEASE: begin
          // Wait for grant to drop before the next request
          if (slave_bus_granted_n) begin
            memDone_q <= 1'b1;
            state_q   <= hsdma_pkg::SA_IDLE;
          end
        end
        default: state_q <= hsdma_pkg::SA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt counting; both slaves share the counter
  wire irqAny = !(slave0_irq_n && slave1_irq_n);
  logic irqPrev_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irqSync_q <= 2'b00;
      irqPrev_q <= 1'b0;
      irqCnt_q  <= 16'h0000;
    end else begin
      irqSync_q <= {irqSync_q[0], irqAny};
      irqPrev_q <= irqSync_q[1];
      if (rstWr && !io.data[0]) irqCnt_q <= 16'h0000;
      else if (irqSync_q[1] && !irqPrev_q) irqCnt_q <= irqCnt_q + 16'h1;
    end
  end
  assign irqCountOk = irqCheck && (irqCnt_q == 16'(hsdma_pkg::IRQ_EXPECTED));

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] statusByte = {5'h00, dataError_q, busError_q, memBusy};
  assign ioRdData = xferHit ? fromSlaveByte :
                    (io.addr == hsdma_pkg::STATUS) ? statusByte :
                    (io.addr == hsdma_pkg::IRQ_LO) ? irqCnt_q[7:0] :
                    (io.addr == hsdma_pkg::IRQ_HI) ? irqCnt_q[15:8] : 8'h00;

endmodule

/* File: bench/hsdma_host_props.sv */
`timescale 1ns/1ps
module hsdma_host_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic memDone_q,
  input wire logic busError_q,
  input wire logic dataError_q,
  input wire logic slvWrite_q,
  input wire logic slvRead_q,
  input wire logic slave0_bus_request_n,
  input wire logic slave1_bus_request_n,
  input wire logic slave_bus_granted_n,
  input wire logic lockout_n,
  input wire logic irqCheck,
  input wire logic irqCountOk
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Either request line low
  wire logic anyReq = !slave0_bus_request_n || !slave1_bus_request_n;

  one_req_a: assert property (slave0_bus_request_n || slave1_bus_request_n)
    else $error("two requests low");
  req_lock_a: assert property (anyReq |-> !lockout_n)
    else $error("request without lockout");
  wr_grant_a: assert property ($rose(slvWrite_q) |-> !$past(slave_bus_granted_n))
    else $error("write before grant");
  rd_req_a: assert property (slvRead_q |-> anyReq)
    else $error("read without request");
  done_once_a: assert property (memDone_q |=> !memDone_q)
    else $error("done too long");
  err_excl_a: assert property (!(busError_q && dataError_q))
    else $error("both errors");
  bus_free_a: assert property (memDone_q |-> slave_bus_granted_n && !anyReq)
    else $error("done with bus held");
  irq_ok_a: assert property (irqCountOk |-> irqCheck)
    else $error("count ok unasked");
endmodule

bind hsdma_host hsdma_host_chk i_chk (.*);

/* File: bench/hsdma_slave_model.sv */
`timescale 1ns/1ps
module hsdma_slave_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        slave0_bus_request_n,
  input  wire logic        slave1_bus_request_n,
  input  wire logic [15:0] slvAddr_q,
  input  wire logic [7:0]  slvWrData_q,
  input  wire logic        slvWrite_q,
  input  wire logic        slvRead_q,
  input  wire logic        noGrant,
  input  wire logic [7:0]  flip,
  input  wire logic [23:0] toSlaveWord,
  output logic             slave_bus_granted_n,
  output logic             slave_transfer_ack_n,
  output logic [7:0]       slvRdData,
  output logic             slaveXferWr,
  output logic [1:0]       slaveXferSel,
  output logic [7:0]       slaveXferData
);
  // Slave micro-sequencer: one pass over its internal bus per sample period
  localparam int unsigned SAMPLE_CYC = 16;
  logic [4:0]  sampleCnt;
  logic [23:0] inReg;
  logic [23:0] outReg;
  wire logic [4:0] busAddr = (sampleCnt == 5'h01) ? hsdma_pkg::SLV_BUS_RD_ADDR :
                             (sampleCnt >= 5'h04 && sampleCnt <= 5'h06) ?
                             hsdma_pkg::SLV_BUS_WR_ADDR : 5'h00;
  wire logic result_latch_strobe_n = (sampleCnt != 5'h02);
  wire logic [1:0] byteSel = 2'(sampleCnt - 5'h04);
  wire logic [7:0] outByte = (byteSel == 2'h3) ? 8'h00 : outReg[byteSel*8 +: 8];

  // Read once, latch the result, then drive it out two counts after the latch strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sampleCnt     <= 5'h00;
      inReg         <= 24'h000000;
      outReg        <= 24'h000000;
      slaveXferWr   <= 1'b0;
      slaveXferSel  <= 2'h0;
      slaveXferData <= 8'h00;
    end else begin
      sampleCnt <= (sampleCnt == 5'(SAMPLE_CYC - 1)) ? 5'h00 : sampleCnt + 5'h01;
      if (busAddr == hsdma_pkg::SLV_BUS_RD_ADDR) inReg <= toSlaveWord;
      if (!result_latch_strobe_n) outReg <= inReg;
      slaveXferWr   <= (busAddr == hsdma_pkg::SLV_BUS_WR_ADDR);
      slaveXferSel  <= byteSel;
      slaveXferData <= outByte;
    end
  end

  logic [7:0] mem [0:255];
  // Each request reaches its processor hold input; noGrant holds both hold inputs inactive
  wire logic hold0_n = slave0_bus_request_n | noGrant;
  wire logic hold1_n = slave1_bus_request_n | noGrant;

  // Idle read data toggles so a stale byte never passes as good
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slave_bus_granted_n  <= 1'b1;
      slave_transfer_ack_n <= 1'b1;
      slvRdData            <= 8'h00;
    end else begin
      slave_bus_granted_n  <= hold0_n & hold1_n;
      slave_transfer_ack_n <= !(slvWrite_q || slvRead_q) || slave_bus_granted_n;
      slvRdData            <= slvRead_q ? mem[slvAddr_q[7:0]] ^ flip : ~slvRdData;
      if (slvWrite_q && !slave_bus_granted_n) begin
        mem[slvAddr_q[7:0]] <= slvWrData_q;
      end
    end
  end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  hsdma_pkg::hsdma_io_s io = '0;
  hsdma_pkg::hsdma_mem_s memReq = '0;
  logic noGrant = 1'b0;
  logic irqCheck = 1'b0;
  logic slaveXferWr;
  logic [1:0] slaveXferSel;
  logic [7:0] slaveXferData;
  logic [7:0] flip = 8'h00;
  logic slave0_irq_n = 1'b1;
  logic slave1_irq_n = 1'b1;
  logic [7:0] ioRdData, memRdData_q, slvRdData, slvWrData_q;
  logic memBusy, memDone_q, busError_q, dataError_q, lockout_n, slaveReset_n;
  logic slave0_bus_request_n, slave1_bus_request_n, slave_bus_granted_n;
  logic slave_transfer_ack_n, slvWrite_q, slvRead_q, irqCountOk;
  logic [15:0] slvAddr_q;
  logic [23:0] toSlaveWord;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  hsdma_host i_dut (.*);
  hsdma_slave_model i_slave (.*);

  always #4 clock = ~clock;

  // Hang guard, far above the expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Every stimulus task starts and ends on a rising edge
  task automatic io_wr(input logic [3:0] a, input logic [7:0] d);
    #1 io = '{1'b1, 1'b0, a, d};
    @(posedge clock);
    #1 io.wr = 1'b0;
    @(posedge clock);
  endtask

  // Read one host I/O byte and compare; transfer bytes lag one cycle
  task automatic io_rd_chk(input logic [3:0] a, input logic [7:0] e);
    #1 io = '{1'b0, 1'b1, a, 8'h00};
    repeat (2) @(posedge clock);
    #1 chk({16'h0, ioRdData}, {16'h0, e});
    io.rd = 1'b0;
    @(posedge clock);
  endtask

  // Host loads a word; the slave echoes it within two sample periods
  task automatic xfer_round(input logic [23:0] w);
    io_wr(hsdma_pkg::XFER_LO, w[7:0]);
    io_wr(hsdma_pkg::XFER_MID, w[15:8]);
    io_wr(hsdma_pkg::XFER_HI, w[23:16]);
    chk(toSlaveWord, w);
    repeat (40) @(posedge clock);
    io_rd_chk(hsdma_pkg::XFER_LO, w[7:0]);
    io_rd_chk(hsdma_pkg::XFER_MID, w[15:8]);
    io_rd_chk(hsdma_pkg::XFER_HI, w[23:16]);
  endtask

  task automatic dma(input logic s, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] f);
    int n;
    n = 0;
    io_wr(hsdma_pkg::SEL_SLAVE, {7'h00, s});
    #1 memReq = '{1'b1, {8'h00, a}, d};
    @(posedge clock);
    #1 memReq.start = 1'b0;
    chk({22'h0, slave1_bus_request_n, slave0_bus_request_n}, s ? 24'h1 : 24'h2);
    while (memBusy !== 1'b0 && n < 4000) begin
      @(posedge clock);
      #1 n++;
    end
    chk({23'h0, memBusy}, 24'h0);
    chk({22'h0, busError_q, dataError_q}, {22'h0, f});
    if (!f[1]) chk({16'h0, memRdData_q}, {16'h0, d ^ flip});
    @(posedge clock);
  endtask

  task automatic irq_pulse(input logic s);
    #1 {slave1_irq_n, slave0_irq_n} = s ? 2'b01 : 2'b10;
    repeat (2) @(posedge clock);
    #1 {slave1_irq_n, slave0_irq_n} = 2'b11;
    repeat (2) @(posedge clock);
  endtask
  ////////////////////////////////////////
  task automatic t_xfer();
    xfer_round(24'hAAAA40);
    xfer_round(24'h555580);
    $display("test xfer done");
  endtask

  task automatic t_dma();
    io_wr(hsdma_pkg::SLV_RESET, 8'h01);
    io_wr(hsdma_pkg::LOCKOUT, 8'h01);
    chk({23'h0, lockout_n}, 24'h0);
    dma(1'b0, 8'h10, 8'hA5, 2'b00);
    dma(1'b1, 8'h11, 8'h5A, 2'b00);
    flip <= 8'h04;
    dma(1'b0, 8'h10, 8'hA5, 2'b01);
    io_rd_chk(hsdma_pkg::STATUS, 8'h04);
    flip <= 8'h00;
    noGrant <= 1'b1;
    dma(1'b1, 8'h12, 8'h3C, 2'b10);
    io_rd_chk(hsdma_pkg::STATUS, 8'h02);
    noGrant <= 1'b0;
    io_wr(hsdma_pkg::SLV_RESET, 8'h00);
    chk({23'h0, slaveReset_n}, 24'h0);
    io_wr(hsdma_pkg::SLV_RESET, 8'h01);
    chk({23'h0, slaveReset_n}, 24'h1);
    $display("test dma done");
  endtask

  task automatic t_irq();
    for (int i = 0; i < 1000; i++) irq_pulse(i[0]);
    repeat (4) @(posedge clock);
    io_rd_chk(hsdma_pkg::IRQ_LO, 8'hE8);
    io_rd_chk(hsdma_pkg::IRQ_HI, 8'h03);
    #1 irqCheck = 1'b1;
    @(posedge clock);
    #1 chk({23'h0, irqCountOk}, 24'h1);
    irq_pulse(1'b0);
    repeat (4) @(posedge clock);
    #1 chk({23'h0, irqCountOk}, 24'h0);
    irqCheck = 1'b0;
    @(posedge clock);
    $display("test irq done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    chk({20'h0, slave0_bus_request_n, slave1_bus_request_n, lockout_n, slaveReset_n},
        24'hE);
    $display("test reset done");
    #1 rstn = 1'b1;
    @(posedge clock);
    t_xfer();
    t_dma();
    t_irq();
    report_and_stop();
  end
endmodule
